// ==== hdl/bmp_pkg.sv ====
// Constants, register map and carrier types for the parallel bus port
package bmp_pkg;
    localparam int DATA_W      = 16;
    localparam int ADDR_W      = 8;
    localparam int REG_W       = 32;
    localparam int QUEUE_DEPTH = 16;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TXDATA = 8'h08;
    localparam logic [ADDR_W-1:0] REG_RXDATA = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_WMARK  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_XFER   = 8'h14;
    localparam logic [ADDR_W-1:0] REG_ISTAT  = 8'h18;
    localparam logic [ADDR_W-1:0] REG_IMASK  = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_CMD    = 8'h20;

    // Field positions
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_MASTER_BIT = 1;
    localparam int CTRL_WIDE_BIT   = 2;
    localparam int CMD_GO_BIT      = 0;
    localparam int CMD_WRITE_BIT   = 1;
    localparam int STAT_TX_LSB     = 0;
    localparam int STAT_RX_LSB     = 8;
    localparam int STAT_BUSY_BIT   = 16;
    localparam int STAT_REQ_BIT    = 17;
    localparam int STAT_FULL_BIT   = 18;
    localparam int NARROW_W        = 8;

    // Interrupt status bits
    localparam int IRQ_W        = 4;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_RX_OVF   = 1;
    localparam int IRQ_TX_UNF   = 2;
    localparam int IRQ_RX_WMARK = 3;

    // Reset values
    localparam int WMARK_RST = 8;
    localparam int XFER_RST  = 1;

    // Timing: master drives one link period as two halves
    localparam int CLK_PERIOD_NS  = 100;
    localparam int LINK_PERIOD_NS = 800;
    localparam int HALF_CYC       = (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
                                    / (2 * CLK_PERIOD_NS);

    typedef enum logic [1:0] {M_IDLE, M_SETUP, M_STROBE} bmp_mstate_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
        logic              we;
        logic              re;
    } bmp_bus_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] d;
        logic              clk;
        logic              wr;
        logic              wait_n;
    } bmp_pins_in_t;

    typedef struct packed {
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] d_oe_n;
        logic              clk;
        logic              clk_oe_n;
        logic              wr;
        logic              wr_oe_n;
        logic              read_n;
        logic              wait_n;
        logic              wait_oe_n;
        logic              read_req;
        logic              rx_full;
    } bmp_pins_out_t;
endpackage

// ==== hdl/bmp_mem.sv ====
// Queue storage with registered read data and write-through
`timescale 1ns/100ps
module bmp_mem #(
    parameter int W     = 16,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_ce,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [W-1:0]  i_wdata,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [W-1:0]  o_rdata
);
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] rdata_q;

    always_ff @(posedge i_clk)
    begin
        if (i_ce && i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Write-through so a word pushed into an empty queue is seen at once
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rdata_q <= '0;
        end
        else if (i_ce)
        begin
            rdata_q <= (i_we && i_waddr == i_raddr) ? i_wdata : mem[i_raddr];
        end
    end

    assign o_rdata = rdata_q;
endmodule

// ==== hdl/bmp_port.sv ====
// Parallel bus port: register file, queues, master and slave link logic
//
// Operation
// R1: The data bus width is selectable as 8 or 16 bits and only the selected lanes are used.
// R2: The direction line is an input in slave mode and an output driven by the port in master mode.
// R3: The interface master drives the direction line high for a write and low for a read.
// R4: In master mode the port drives its active-low read strobe during read accesses.
// R5: In slave mode the read strobe is unused and held high.
// R6: The read request output is high while the transmit queue holds at least one access worth.
// R7: The receive-full output is high while the receive queue level is at or above the watermark.
// R8: A low wait line stalls the access, which completes only once wait is released.
// R9: The clock or select line is driven by whichever party masters the interface.
// R10: The data lanes are released unless driving master write data or slave read data.
`timescale 1ns/100ps
module bmp_port
    import bmp_pkg::*;
#(
    parameter int DEPTH = bmp_pkg::QUEUE_DEPTH,
    parameter int HALF  = bmp_pkg::HALF_CYC
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic                    i_ce,
    input  wire bmp_pkg::bmp_bus_req_t   i_bus,
    output logic [bmp_pkg::REG_W-1:0]    o_rdata,
    output logic                         o_irq,
    input  wire bmp_pkg::bmp_pins_in_t   i_pins,
    output bmp_pkg::bmp_pins_out_t       o_pins
);
    import bmp_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam int HW = $clog2(HALF) + 1;
    localparam logic [HW-1:0] TMR_LOAD = HW'(HALF - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    typedef struct packed {
        logic                       en;
        logic                       master;
        logic                       wide;
        logic [CW-1:0]              wmark;
        logic [CW-1:0]              xfer;
        logic [IRQ_W-1:0]           ist;
        logic [IRQ_W-1:0]           imask;
        logic [PW-1:0]              tx_wp;
        logic [PW-1:0]              tx_rp;
        logic [PW-1:0]              rx_wp;
        logic [PW-1:0]              rx_rp;
        logic [CW-1:0]              tx_cnt;
        logic [CW-1:0]              rx_cnt;
        logic [2:0]                 s_clk;
        logic [2:0]                 s_wr;
        logic [2:0]                 s_wait;
        logic [2:0][DATA_W-1:0]     s_d;
        logic                       clk_st;
        logic                       wr_st;
        logic                       wait_st;
        bmp_mstate_t                ms;
        logic                       m_wr;
        logic [CW-1:0]              m_left;
        logic [HW-1:0]              tmr;
        logic [REG_W-1:0]           rdata;
        logic                       irq;
        bmp_pins_out_t              pins;
    } bmp_state_t;

    bmp_state_t q;
    bmp_state_t n;

    logic              tx_push;
    logic              tx_pop;
    logic              rx_push;
    logic              rx_pop;
    logic [DATA_W-1:0] rx_wdata;
    logic [DATA_W-1:0] tx_rdata;
    logic [DATA_W-1:0] rx_rdata;
    logic [IRQ_W-1:0]  ev;
    logic [IRQ_W-1:0]  iclr;
    logic [DATA_W-1:0] sample;
    logic              clk_rise;
    logic              drive_d;

    // A synchronised level changes only when stages two and three agree
    function automatic logic settle(input logic st, input logic s1, input logic s2);
        settle = (s1 == s2) ? s2 : st;
    endfunction

    function automatic logic [DATA_W-1:0] lanes(input logic wide);
        lanes = wide ? {DATA_W{1'b1}} : DATA_W'({NARROW_W{1'b1}});
    endfunction

    function automatic logic [CW-1:0] step(input logic [CW-1:0] c, input logic up,
                                           input logic dn);
        step = CW'(c + CW'(up) - CW'(dn));
    endfunction

    always_comb
    begin
        n        = q;
        tx_push  = 1'b0;
        tx_pop   = 1'b0;
        rx_push  = 1'b0;
        rx_pop   = 1'b0;
        rx_wdata = '0;
        ev       = '0;
        iclr     = '0;
        drive_d  = 1'b0;

        n.s_clk  = {q.s_clk[1:0], i_pins.clk};
        n.s_wr   = {q.s_wr[1:0], i_pins.wr};
        n.s_wait = {q.s_wait[1:0], i_pins.wait_n};
        n.s_d    = {q.s_d[1:0], i_pins.d};
        n.clk_st  = settle(q.clk_st, q.s_clk[1], q.s_clk[2]);
        n.wr_st   = settle(q.wr_st, q.s_wr[1], q.s_wr[2]);
        n.wait_st = settle(q.wait_st, q.s_wait[1], q.s_wait[2]);
        clk_rise  = n.clk_st && !q.clk_st;
        // R1: unused lanes captured as zero
        sample    = q.s_d[2] & lanes(q.wide);

        n.rdata = '0;
        if (i_bus.we)
        begin
            case (i_bus.addr)
                REG_CTRL:
                begin
                    n.en     = i_bus.wdata[CTRL_EN_BIT];
                    n.master = i_bus.wdata[CTRL_MASTER_BIT];
                    n.wide   = i_bus.wdata[CTRL_WIDE_BIT];
                    // Mode change abandons a master access in flight, but a master state step due in that same cycle overrides it
                    n.ms     = M_IDLE;
                end
                REG_TXDATA:
                begin
                    // Push to a full queue is dropped
                    tx_push = (q.tx_cnt != FULL_CNT);
                end
                REG_WMARK: n.wmark = i_bus.wdata[CW-1:0];
                REG_XFER:  n.xfer  = (i_bus.wdata[CW-1:0] == '0) ? CW'(1) : i_bus.wdata[CW-1:0];
                REG_ISTAT: iclr    = i_bus.wdata[IRQ_W-1:0];
                REG_IMASK: n.imask = i_bus.wdata[IRQ_W-1:0];
                REG_CMD:
                begin
                    if (q.en && q.master && q.ms == M_IDLE && i_bus.wdata[CMD_GO_BIT])
                    begin
                        n.ms     = M_SETUP;
                        n.m_wr   = i_bus.wdata[CMD_WRITE_BIT];
                        n.m_left = q.xfer;
                        n.tmr    = TMR_LOAD;
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (i_bus.re)
        begin
            case (i_bus.addr)
                REG_CTRL:   n.rdata = REG_W'({q.wide, q.master, q.en});
                REG_STATUS:
                begin
                    n.rdata[STAT_TX_LSB +: CW] = q.tx_cnt;
                    n.rdata[STAT_RX_LSB +: CW] = q.rx_cnt;
                    n.rdata[STAT_BUSY_BIT]     = (q.ms != M_IDLE);
                    n.rdata[STAT_REQ_BIT]      = q.pins.read_req;
                    n.rdata[STAT_FULL_BIT]     = q.pins.rx_full;
                end
                REG_RXDATA:
                begin
                    // Reading an empty queue returns zero and pops nothing
                    if (q.rx_cnt != '0)
                    begin
                        n.rdata = REG_W'(rx_rdata);
                        rx_pop  = 1'b1;
                    end
                end
                REG_WMARK:  n.rdata = REG_W'(q.wmark);
                REG_XFER:   n.rdata = REG_W'(q.xfer);
                REG_ISTAT:  n.rdata = REG_W'(q.ist);
                REG_IMASK:  n.rdata = REG_W'(q.imask);
                default:    n.rdata = '0;
            endcase
        end

        if (q.en && q.master)
        begin
            case (q.ms)
                M_SETUP:
                begin
                    // Hold off until there is data to send or room to receive
                    if (q.m_wr ? (q.tx_cnt != '0) : (q.rx_cnt != FULL_CNT))
                    begin
                        if (q.tmr == '0)
                        begin
                            n.ms  = M_STROBE;
                            n.tmr = TMR_LOAD;
                        end
                        else
                        begin
                            n.tmr = HW'(q.tmr - 1'b1);
                        end
                    end
                end
                M_STROBE:
                begin
                    if (q.tmr != '0)
                    begin
                        n.tmr = HW'(q.tmr - 1'b1);
                    end
                    // R8: complete only once wait is released
                    else if (q.wait_st)
                    begin
                        if (q.m_wr)
                        begin
                            tx_pop = 1'b1;
                        end
                        else
                        begin
                            rx_push  = 1'b1;
                            rx_wdata = sample;
                        end
                        n.m_left = CW'(q.m_left - 1'b1);
                        n.tmr    = TMR_LOAD;
                        if (q.m_left == CW'(1))
                        begin
                            n.ms          = M_IDLE;
                            ev[IRQ_DONE]  = 1'b1;
                        end
                        else
                        begin
                            n.ms = M_SETUP;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
        else if (q.en && clk_rise)
        begin
            // Slave: external master's rising edge completes a word
            if (q.wr_st)
            begin
                if (q.rx_cnt != FULL_CNT)
                begin
                    rx_push  = 1'b1;
                    rx_wdata = sample;
                end
                else
                begin
                    ev[IRQ_RX_OVF] = 1'b1;
                end
            end
            else if (q.tx_cnt != '0)
            begin
                tx_pop = 1'b1;
            end
            else
            begin
                ev[IRQ_TX_UNF] = 1'b1;
            end
        end

        n.tx_wp  = tx_push ? PW'(q.tx_wp + 1'b1) : q.tx_wp;
        n.tx_rp  = tx_pop  ? PW'(q.tx_rp + 1'b1) : q.tx_rp;
        n.rx_wp  = rx_push ? PW'(q.rx_wp + 1'b1) : q.rx_wp;
        n.rx_rp  = rx_pop  ? PW'(q.rx_rp + 1'b1) : q.rx_rp;
        n.tx_cnt = step(q.tx_cnt, tx_push, tx_pop);
        n.rx_cnt = step(q.rx_cnt, rx_push, rx_pop);

        // Pin drive, released by default (enables low means driving)
        n.pins.d         = '0;
        n.pins.d_oe_n    = '1;
        n.pins.clk       = 1'b0;
        n.pins.clk_oe_n  = 1'b1;
        n.pins.wr        = 1'b0;
        n.pins.wr_oe_n   = 1'b1;
        // R5: strobe idle high
        n.pins.read_n    = 1'b1;
        n.pins.wait_n    = 1'b1;
        n.pins.wait_oe_n = 1'b1;
        if (n.en && n.master)
        begin
            // R9: master owns the clock line
            n.pins.clk_oe_n = 1'b0;
            n.pins.clk      = (n.ms == M_STROBE);
            // R2: direction is an output as master
            n.pins.wr_oe_n  = 1'b0;
            // R3: high for write, low for read
            n.pins.wr       = (n.ms != M_IDLE) && n.m_wr;
            // R4: strobe enables slave read data
            n.pins.read_n   = !((n.ms != M_IDLE) && !n.m_wr);
            drive_d         = (n.ms != M_IDLE) && n.m_wr;
        end
        else if (n.en)
        begin
            // Slave stalls the external master while it cannot serve
            n.pins.wait_oe_n = 1'b0;
            // R8: stall while unable to serve
            n.pins.wait_n    = n.wr_st ? (n.rx_cnt != FULL_CNT) : (n.tx_cnt != '0);
            drive_d          = !n.wr_st;
        end
        // R10: lanes driven only for outgoing data
        if (drive_d)
        begin
            n.pins.d      = tx_rdata & lanes(n.wide);
            n.pins.d_oe_n = ~lanes(n.wide);
        end
        // R6: request once one access worth is queued
        n.pins.read_req = (n.tx_cnt >= n.xfer);
        // R7: level against watermark
        n.pins.rx_full  = (n.rx_cnt >= n.wmark);
        ev[IRQ_RX_WMARK] = n.pins.rx_full && !q.pins.rx_full;

        // Hardware set wins over software clear
        n.ist = (q.ist & ~iclr) | ev;
        n.irq = |(n.ist & n.imask);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            q                <= '0;
            q.wmark          <= CW'(WMARK_RST);
            q.xfer           <= CW'(XFER_RST);
            q.s_clk          <= '0;
            q.s_wr           <= '0;
            q.s_wait         <= '1;
            q.wait_st        <= 1'b1;
            q.ms             <= M_IDLE;
            q.pins.d_oe_n    <= '1;
            q.pins.clk_oe_n  <= 1'b1;
            q.pins.wr_oe_n   <= 1'b1;
            q.pins.read_n    <= 1'b1;
            q.pins.wait_n    <= 1'b1;
            q.pins.wait_oe_n <= 1'b1;
        end
        else if (i_ce)
        begin
            q <= n;
        end
    end

    bmp_mem #(.W(DATA_W), .DEPTH(DEPTH)) u_tx_mem (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_we    (tx_push),
        .i_waddr (q.tx_wp),
        .i_wdata (i_bus.wdata[DATA_W-1:0]),
        .i_raddr (n.tx_rp),
        .o_rdata (tx_rdata)
    );

    bmp_mem #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_mem (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_we    (rx_push),
        .i_waddr (q.rx_wp),
        .i_wdata (rx_wdata),
        .i_raddr (n.rx_rp),
        .o_rdata (rx_rdata)
    );

    assign o_rdata = q.rdata;
    assign o_irq   = q.irq;
    assign o_pins  = q.pins;

    // R1: narrow mode upper lanes
    a_narrow_lanes: assert property (@(posedge i_clk) disable iff (i_rst) // R1
        !q.wide |-> (&q.pins.d_oe_n[DATA_W-1:NARROW_W] && q.pins.d[DATA_W-1:NARROW_W] == '0))
        else $error("upper lanes used in narrow mode");

    // R2: direction line ownership
    a_dir_owner: assert property (@(posedge i_clk) disable iff (i_rst) // R2
        q.en |-> (q.pins.wr_oe_n == !q.master))
        else $error("direction line owned by wrong party");

    // R3: direction level per access
    a_dir_level: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        (q.en && q.master && q.ms != M_IDLE) |-> (q.pins.wr == q.m_wr && q.pins.read_n == q.m_wr))
        else $error("direction level disagrees with access");

    // R4: strobe held over the read
    a_read_strobe: assert property (@(posedge i_clk) disable iff (i_rst) // R4
        (i_ce && !i_bus.we && q.en && q.master && q.ms == M_SETUP && !q.m_wr)
        |=> !q.pins.read_n)
        else $error("read strobe missing during master read");

    // R5: slave strobe high
    a_slave_strobe: assert property (@(posedge i_clk) disable iff (i_rst) // R5
        (!q.master || !q.en) |-> q.pins.read_n)
        else $error("read strobe active outside master mode");

    // R6: request tracks queue level
    a_read_req: assert property (@(posedge i_clk) disable iff (i_rst) // R6
        q.pins.read_req == (q.tx_cnt >= q.xfer))
        else $error("read request does not follow transmit level");

    // R7: full rises above the watermark only after a register write or a receive push
    a_rx_full: assert property (@(posedge i_clk) disable iff (i_rst) // R7
        (i_ce && q.pins.rx_full && $past(q.rx_cnt) < $past(q.wmark)) |-> $past(i_bus.we)
        || $past(rx_push))
        else $error("receive full rose without a cause");

    // R8: wait stalls completion
    a_wait_stall: assert property (@(posedge i_clk) disable iff (i_rst) // R8
        (i_ce && !i_bus.we && q.master && q.ms == M_STROBE && q.tmr == '0 && !q.wait_st)
        |=> (q.ms == M_STROBE && $stable(q.m_left)))
        else $error("access finished while wait was low");

    // R9: clock line ownership
    a_clk_owner: assert property (@(posedge i_clk) disable iff (i_rst) // R9
        (q.pins.clk_oe_n == !(q.en && q.master)))
        else $error("clock line owned by wrong party");

    // R10: lanes released when idle
    a_data_release: assert property (@(posedge i_clk) disable iff (i_rst) // R10
        (q.pins.d_oe_n != '1) |-> (q.en && (q.master ? (q.ms != M_IDLE && q.m_wr) : !q.wr_st)))
        else $error("data lanes driven without outgoing data");

    a_irq_level: assert property (@(posedge i_clk) disable iff (i_rst)
        o_irq == |(q.ist & q.imask))
        else $error("interrupt output disagrees with status and mask");
endmodule

// ==== sim/bmp_partner.sv ====
// Far-side model: slave to a master port, line resolution in all modes
`timescale 1ns/100ps
module bmp_partner (
    input  wire logic                        i_clk,
    input  wire logic                        i_stall,
    input  wire logic [bmp_pkg::DATA_W-1:0]  i_rd_word,
    input  wire logic                        i_ext_clk,
    input  wire logic                        i_ext_wr,
    input  wire logic [bmp_pkg::DATA_W-1:0]  i_ext_d,
    input  wire bmp_pkg::bmp_pins_out_t      i_port,
    output bmp_pkg::bmp_pins_in_t            o_pins,
    output logic      [bmp_pkg::DATA_W-1:0]  o_last_wr
);
    import bmp_pkg::*;
    logic clk_q;

    always_comb
    begin
        o_pins.clk    = i_port.clk_oe_n ? i_ext_clk : i_port.clk;
        o_pins.wr     = i_port.wr_oe_n ? i_ext_wr : i_port.wr;
        o_pins.wait_n = i_port.wait_oe_n ? !i_stall : i_port.wait_n;
        for (int i = 0; i < DATA_W; i++)
        begin
            if (!i_port.d_oe_n[i])
                o_pins.d[i] = i_port.d[i];
            else if (!i_port.read_n)
                o_pins.d[i] = i_rd_word[i];
            else
                o_pins.d[i] = i_ext_d[i];
        end
    end

    // write data taken on clock rise
    always_ff @(posedge i_clk)
    begin
        clk_q <= o_pins.clk;
        if (o_pins.clk && !clk_q && o_pins.wr && !i_port.clk_oe_n)
            o_last_wr <= o_pins.d;
    end
endmodule

// ==== sim/bmp_port_tb.sv ====
// Self-checking bench for the parallel bus port
`timescale 1ns/100ps
module bmp_port_tb;
    import bmp_pkg::*;
    logic              i_clk;
    logic              i_rst;
    bmp_bus_req_t      bus;
    logic [REG_W-1:0]  rdata;
    logic              irq;
    bmp_pins_in_t      pins_in;
    bmp_pins_out_t     pins_out;
    logic              stall;
    logic              ext_clk;
    logic              ext_wr;
    logic [DATA_W-1:0] ext_d;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] last_wr;
    logic [DATA_W-1:0] w0;
    logic [DATA_W-1:0] w1;
    logic [REG_W-1:0]  v;
    int                miscompares;
    int                n_tests;

    bmp_port dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_bus(bus),
        .o_rdata(rdata), .o_irq(irq), .i_pins(pins_in), .o_pins(pins_out));
    bmp_partner partner (.i_clk(i_clk), .i_stall(stall), .i_rd_word(rd_word),
        .i_ext_clk(ext_clk), .i_ext_wr(ext_wr), .i_ext_d(ext_d),
        .i_port(pins_out), .o_pins(pins_in), .o_last_wr(last_wr));

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Word seen on the link: unused upper lanes belong to the far side
    function automatic logic [DATA_W-1:0] exp_lanes(input logic wide,
                                                    input logic [DATA_W-1:0] own,
                                                    input logic [DATA_W-1:0] far);
        exp_lanes = wide ? own : {far[DATA_W-1:NARROW_W], own[NARROW_W-1:0]};
    endfunction

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge i_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.we    <= 1'b1;
        @(posedge i_clk);
        bus.we    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
        @(posedge i_clk);
        bus.addr <= a;
        bus.re   <= 1'b1;
        @(posedge i_clk);
        bus.re   <= 1'b0;
        @(negedge i_clk);
        d = rdata;
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(negedge i_clk);
            n++;
        end
        if (irq !== 1'b1)
        begin
            miscompares++;
            $display("wrong value at %0t: no interrupt", $time);
            print_verdict();
        end
    endtask

    // Link clock low half with lines set up early, then the high half
    task automatic link_lo(input logic wr, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        ext_wr <= wr;
        ext_d  <= d;
        repeat (4) @(negedge i_clk);
    endtask

    task automatic link_hi();
        @(posedge i_clk);
        ext_clk <= 1'b1;
        repeat (4) @(posedge i_clk);
        ext_clk <= 1'b0;
        repeat (4) @(negedge i_clk);
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    initial
    begin
        i_rst = 1'b1;
        bus = '0;
        {stall, ext_clk, ext_wr, ext_d, rd_word} = '0;
        miscompares = 0;
        n_tests = 0;
        w0 = DATA_W'($urandom(57651));
        w1 = DATA_W'($urandom);
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        reg_rd(REG_WMARK, v);
        chk(v, 32'(WMARK_RST));
        reg_rd(8'h24, v);
        chk(v, 32'h0);
        chk(32'({pins_out.d_oe_n, pins_out.read_n}), 32'h1ffff);
        // Wide master write of two words
        reg_wr(REG_CTRL, 32'h7);
        reg_wr(REG_XFER, 32'h2);
        reg_wr(REG_TXDATA, 32'(w0));
        reg_wr(REG_TXDATA, 32'(w1));
        reg_wr(REG_IMASK, 32'h1);
        reg_wr(REG_CMD, 32'h3);
        wait_irq();
        chk(32'(last_wr), 32'(exp_lanes(1'b1, w1, ext_d)));
        reg_wr(REG_ISTAT, 32'h1);
        @(negedge i_clk);
        chk(32'(irq), 32'h0);
        // Narrow write: upper lanes stay with the far side
        reg_wr(REG_CTRL, 32'h3);
        ext_d <= DATA_W'($urandom);
        reg_wr(REG_XFER, 32'h1);
        reg_wr(REG_TXDATA, 32'(w0));
        reg_wr(REG_CMD, 32'h3);
        wait_irq();
        chk(32'(last_wr), 32'(exp_lanes(1'b0, w0, ext_d)));
        reg_wr(REG_ISTAT, 32'h1);
        // Master read stalled by the far side
        rd_word <= DATA_W'($urandom);
        stall <= 1'b1;
        reg_wr(REG_CTRL, 32'h7);
        reg_wr(REG_CMD, 32'h1);
        repeat (30) @(negedge i_clk);
        chk(32'({pins_out.read_n, pins_out.wr}), 32'h0);
        reg_rd(REG_STATUS, v);
        chk(32'(v[STAT_BUSY_BIT]), 32'h1);
        @(posedge i_clk);
        stall <= 1'b0;
        wait_irq();
        reg_rd(REG_RXDATA, v);
        chk(v, 32'(rd_word));
        reg_wr(REG_ISTAT, 32'h1);
        // Slave mode: far side masters the link
        reg_wr(REG_CTRL, 32'h5);
        reg_wr(REG_WMARK, 32'h2);
        reg_wr(REG_XFER, 32'h2);
        reg_wr(REG_TXDATA, 32'(w0));
        @(negedge i_clk);
        chk(32'({pins_out.read_n, pins_out.wr_oe_n, pins_out.clk_oe_n, pins_out.read_req,
            pins_out.wait_oe_n, pins_out.wait_n}), 32'h39);
        reg_wr(REG_TXDATA, 32'(w1));
        @(negedge i_clk);
        chk(32'(pins_out.read_req), 32'h1);
        link_lo(1'b0, '0);
        chk(32'(pins_in.d), 32'(w0));
        link_hi();
        chk(32'(pins_out.read_req), 32'h0);
        w1 = DATA_W'($urandom);
        link_lo(1'b1, w1);
        link_hi();
        chk(32'(pins_out.rx_full), 32'h0);
        link_lo(1'b1, DATA_W'($urandom));
        link_hi();
        chk(32'({pins_out.rx_full, irq}), 32'h2);
        reg_rd(REG_RXDATA, v);
        chk(v, 32'(w1));
        @(negedge i_clk);
        chk(32'(pins_out.rx_full), 32'h0);
        // Overfill the receive queue, then drain transmit past empty
        repeat (16)
        begin
            link_lo(1'b1, DATA_W'($urandom));
            link_hi();
        end
        chk(32'({pins_out.rx_full, pins_out.wait_n}), 32'h2);
        repeat (2)
        begin
            link_lo(1'b0, '0);
            link_hi();
        end
        reg_rd(REG_ISTAT, v);
        chk(v, 32'he);
        print_verdict();
    end
endmodule
